// >>> hw/tap_reconf_ctrl.sv
// Summary of operation
// - Instruction register is ten bits long
// - Boundary chain holds 174 cells
// - SAMPLE/PRELOAD captures pins, preloads outputs
// - EXTEST drives outputs, captures inputs
// - BYPASS gives one-bit register path
// - Identification register shifts out on data
// - 32-bit user code register shifts out
// - Start instruction pulls request low in idle
// - Request released when controller leaves idle
// - Hold instruction keeps request low continuously
// - Hold lasts until start instruction issued
// - Programming runs over four-wire test port
module tap_reconf_ctrl #(
  parameter int unsigned       BSR_LEN  = tap_reconf_pkg::BSR_LEN,
  parameter logic [31:0]       ID_VALUE = 32'h0000_0001,  // Arbitrary value
  parameter logic [31:0]       USER_VAL = 32'hffff_ffff
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  // Test port pins, asynchronous to core_clk
  input  wire tap_reconf_pkg::tap_pins_t pins,
  output logic                      tdo,
  output logic                      tdo_oe_n,
  // Reconfiguration request, open drain
  output logic                      reconfig_request_n,
  output logic                      reconfig_request_oe_n,
  // Boundary cells facing the core
  input  wire logic [BSR_LEN-1:0]   pin_in,
  output logic [BSR_LEN-1:0]        pin_out,
  output logic                      extest_active
);

  localparam int unsigned IRL = tap_reconf_pkg::IR_LEN;
  localparam int unsigned CL  = tap_reconf_pkg::CODE_LEN;

  // Two-stage synchronisers; stage one only feeds stage two
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       tck_prev;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1    <= 3'h0;
      sync2    <= 3'h0;
      tck_prev <= 1'b0;
    end else begin
      sync1    <= pins;
      sync2    <= sync1;
      tck_prev <= sync2[2];
    end
  end

  logic tck_s, tms_s, tdi_s, tck_rise, tck_fall;
  assign tck_s    = sync2[2];
  assign tms_s    = sync2[1];
  assign tdi_s    = sync2[0];
  assign tck_rise = tck_s & ~tck_prev;
  assign tck_fall = ~tck_s & tck_prev;

  function automatic tap_reconf_pkg::tap_state_t tap_next(input tap_reconf_pkg::tap_state_t s,
                                                          input logic m);
    case (s)
      tap_reconf_pkg::ST_RESET:    tap_next = m ? tap_reconf_pkg::ST_RESET   : tap_reconf_pkg::ST_IDLE;
      tap_reconf_pkg::ST_IDLE:     tap_next = m ? tap_reconf_pkg::ST_SEL_DR  : tap_reconf_pkg::ST_IDLE;
      tap_reconf_pkg::ST_SEL_DR:   tap_next = m ? tap_reconf_pkg::ST_SEL_IR  : tap_reconf_pkg::ST_CAP_DR;
      tap_reconf_pkg::ST_CAP_DR:   tap_next = m ? tap_reconf_pkg::ST_EXIT1_DR : tap_reconf_pkg::ST_SHIFT_DR;
      tap_reconf_pkg::ST_SHIFT_DR: tap_next = m ? tap_reconf_pkg::ST_EXIT1_DR : tap_reconf_pkg::ST_SHIFT_DR;
      tap_reconf_pkg::ST_EXIT1_DR: tap_next = m ? tap_reconf_pkg::ST_UPD_DR  : tap_reconf_pkg::ST_PAUSE_DR;
      tap_reconf_pkg::ST_PAUSE_DR: tap_next = m ? tap_reconf_pkg::ST_EXIT2_DR : tap_reconf_pkg::ST_PAUSE_DR;
      tap_reconf_pkg::ST_EXIT2_DR: tap_next = m ? tap_reconf_pkg::ST_UPD_DR  : tap_reconf_pkg::ST_SHIFT_DR;
      tap_reconf_pkg::ST_UPD_DR:   tap_next = m ? tap_reconf_pkg::ST_SEL_DR  : tap_reconf_pkg::ST_IDLE;
      tap_reconf_pkg::ST_SEL_IR:   tap_next = m ? tap_reconf_pkg::ST_RESET   : tap_reconf_pkg::ST_CAP_IR;
      tap_reconf_pkg::ST_CAP_IR:   tap_next = m ? tap_reconf_pkg::ST_EXIT1_IR : tap_reconf_pkg::ST_SHIFT_IR;
      tap_reconf_pkg::ST_SHIFT_IR: tap_next = m ? tap_reconf_pkg::ST_EXIT1_IR : tap_reconf_pkg::ST_SHIFT_IR;
      tap_reconf_pkg::ST_EXIT1_IR: tap_next = m ? tap_reconf_pkg::ST_UPD_IR  : tap_reconf_pkg::ST_PAUSE_IR;
      tap_reconf_pkg::ST_PAUSE_IR: tap_next = m ? tap_reconf_pkg::ST_EXIT2_IR : tap_reconf_pkg::ST_PAUSE_IR;
      tap_reconf_pkg::ST_EXIT2_IR: tap_next = m ? tap_reconf_pkg::ST_UPD_IR  : tap_reconf_pkg::ST_SHIFT_IR;
      tap_reconf_pkg::ST_UPD_IR:   tap_next = m ? tap_reconf_pkg::ST_SEL_DR  : tap_reconf_pkg::ST_IDLE;
      default:                     tap_next = tap_reconf_pkg::ST_RESET;
    endcase
  endfunction : tap_next

  function automatic tap_reconf_pkg::dr_sel_t decode(input logic [9:0] op);
    case (op)
      tap_reconf_pkg::OP_EXTEST,
      tap_reconf_pkg::OP_SAMPLE:   decode = tap_reconf_pkg::SEL_BSR;
      tap_reconf_pkg::OP_IDCODE:   decode = tap_reconf_pkg::SEL_IDCODE;
      tap_reconf_pkg::OP_USERCODE: decode = tap_reconf_pkg::SEL_USERCODE;
      default:                     decode = tap_reconf_pkg::SEL_BYPASS;
    endcase
  endfunction : decode

  tap_reconf_pkg::tap_state_t state, next_state;
  logic [IRL-1:0]     ir_shift, next_ir_shift, ir, next_ir;
  logic [BSR_LEN-1:0] bsr, next_bsr, bsr_upd, next_bsr_upd;
  logic [CL-1:0]      code_sr, next_code_sr;
  logic               byp, next_byp;
  logic               next_tdo, next_tdo_oe_n;
  logic               hold, next_hold;
  logic               next_req_low;
  tap_reconf_pkg::dr_sel_t sel;

  assign sel = decode(ir);

  always_comb begin
    next_state    = state;
    next_ir_shift = ir_shift;
    next_ir       = ir;
    next_bsr      = bsr;
    next_bsr_upd  = bsr_upd;
    next_code_sr  = code_sr;
    next_byp      = byp;
    next_tdo      = tdo;
    next_tdo_oe_n = tdo_oe_n;
    if (tck_rise) begin
      next_state = tap_next(state, tms_s);
      case (state)
        tap_reconf_pkg::ST_RESET: begin
          next_ir = tap_reconf_pkg::OP_IDCODE;
        end
        tap_reconf_pkg::ST_CAP_IR: begin
          next_ir_shift = {{(IRL-2){1'b0}}, tap_reconf_pkg::IR_CAPTURE};
        end
        tap_reconf_pkg::ST_SHIFT_IR: begin
          next_ir_shift = {tdi_s, ir_shift[IRL-1:1]};
        end
        tap_reconf_pkg::ST_UPD_IR: begin
          next_ir = ir_shift;
        end
        tap_reconf_pkg::ST_CAP_DR: begin
          next_bsr = pin_in;
          next_byp = 1'b0;
          next_code_sr = (sel == tap_reconf_pkg::SEL_IDCODE) ? ID_VALUE : USER_VAL;
        end
        tap_reconf_pkg::ST_SHIFT_DR: begin
          next_byp     = tdi_s;
          next_bsr     = {tdi_s, bsr[BSR_LEN-1:1]};
          next_code_sr = {tdi_s, code_sr[CL-1:1]};
        end
        tap_reconf_pkg::ST_UPD_DR: begin
          if (sel == tap_reconf_pkg::SEL_BSR) begin
            next_bsr_upd = bsr;
          end
        end
        default: begin
        end
      endcase
    end
    // Output changes on the falling test clock edge
    if (tck_fall) begin
      next_tdo_oe_n = 1'b1;
      next_tdo      = 1'b0;
      if (state == tap_reconf_pkg::ST_SHIFT_IR) begin
        next_tdo_oe_n = 1'b0;
        next_tdo      = ir_shift[0];
      end else if (state == tap_reconf_pkg::ST_SHIFT_DR) begin
        next_tdo_oe_n = 1'b0;
        case (sel)
          tap_reconf_pkg::SEL_BSR:      next_tdo = bsr[0];
          tap_reconf_pkg::SEL_IDCODE,
          tap_reconf_pkg::SEL_USERCODE: next_tdo = code_sr[0];
          default:                      next_tdo = byp;
        endcase
      end
    end
  end

  // Reconfiguration request logic
  always_comb begin
    next_hold    = hold;
    next_req_low = 1'b0;
    if (ir == tap_reconf_pkg::OP_HOLD_RECONF) begin
      next_hold = 1'b1;
    end
    if (ir == tap_reconf_pkg::OP_START_RECONF) begin
      next_hold = 1'b0;
    end
    if (ir == tap_reconf_pkg::OP_START_RECONF && state == tap_reconf_pkg::ST_IDLE) begin
      next_req_low = 1'b1;
    end
    if (next_hold) begin
      next_req_low = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state                 <= tap_reconf_pkg::ST_RESET;
      ir_shift              <= '0;
      ir                    <= tap_reconf_pkg::OP_IDCODE;
      bsr                   <= '0;
      bsr_upd               <= '0;
      code_sr               <= '0;
      byp                   <= 1'b0;
      tdo                   <= 1'b0;
      tdo_oe_n              <= 1'b1;
      hold                  <= 1'b0;
      reconfig_request_n    <= 1'b1;
      reconfig_request_oe_n <= 1'b1;
      pin_out               <= '0;
      extest_active         <= 1'b0;
    end else begin
      state                 <= next_state;
      ir_shift              <= next_ir_shift;
      ir                    <= next_ir;
      bsr                   <= next_bsr;
      bsr_upd               <= next_bsr_upd;
      code_sr               <= next_code_sr;
      byp                   <= next_byp;
      tdo                   <= next_tdo;
      tdo_oe_n              <= next_tdo_oe_n;
      hold                  <= next_hold;
      // Open drain: only ever drive low
      reconfig_request_n    <= 1'b0;
      reconfig_request_oe_n <= ~next_req_low;
      pin_out               <= next_bsr_upd;
      extest_active         <= (next_ir == tap_reconf_pkg::OP_EXTEST);
    end
  end

  // Assertions
  property p_req_idle;
    @(posedge core_clk) disable iff (!arst_n)
      (ir == tap_reconf_pkg::OP_START_RECONF && state == tap_reconf_pkg::ST_IDLE) |=> !reconfig_request_oe_n;
  endproperty
  a_req_idle: assert property (p_req_idle) else $error("request not driven in idle");

  property p_req_release;
    @(posedge core_clk) disable iff (!arst_n)
      (ir == tap_reconf_pkg::OP_START_RECONF && state != tap_reconf_pkg::ST_IDLE) |=> reconfig_request_oe_n;
  endproperty
  a_req_release: assert property (p_req_release) else $error("request not released");

  property p_hold;
    @(posedge core_clk) disable iff (!arst_n)
      (ir == tap_reconf_pkg::OP_HOLD_RECONF) |=> !reconfig_request_oe_n;
  endproperty
  a_hold: assert property (p_hold) else $error("hold did not drive request");

  property p_hold_stays;
    @(posedge core_clk) disable iff (!arst_n)
      (hold && ir != tap_reconf_pkg::OP_START_RECONF) |=> hold;
  endproperty
  a_hold_stays: assert property (p_hold_stays) else $error("hold dropped early");

  property p_unknown;
    @(posedge core_clk) disable iff (!arst_n)
      (!hold && ir != tap_reconf_pkg::OP_START_RECONF && ir != tap_reconf_pkg::OP_HOLD_RECONF)
        |=> reconfig_request_oe_n;
  endproperty
  a_unknown: assert property (p_unknown) else $error("request driven by other opcode");

  property p_ir_update;
    @(posedge core_clk) disable iff (!arst_n)
      (tck_rise && state == tap_reconf_pkg::ST_UPD_IR) |=> (ir == $past(ir_shift));
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("instruction not updated");

  property p_bypass;
    @(posedge core_clk) disable iff (!arst_n)
      (tck_fall && state == tap_reconf_pkg::ST_SHIFT_DR && sel == tap_reconf_pkg::SEL_BYPASS)
        |=> (tdo == $past(byp) && !tdo_oe_n);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass output wrong");

  property p_code_cap;
    @(posedge core_clk) disable iff (!arst_n)
      (tck_rise && state == tap_reconf_pkg::ST_CAP_DR && sel == tap_reconf_pkg::SEL_IDCODE) |=> code_sr == ID_VALUE;
  endproperty
  a_code_cap: assert property (p_code_cap) else $error("id not captured");

  property p_user_cap;
    @(posedge core_clk) disable iff (!arst_n)
      (tck_rise && state == tap_reconf_pkg::ST_CAP_DR && sel == tap_reconf_pkg::SEL_USERCODE) |=> code_sr == USER_VAL;
  endproperty
  a_user_cap: assert property (p_user_cap) else $error("user code not captured");

  // update into idle, then the line goes low
  sequence s_start_into_idle;
    tck_rise && state == tap_reconf_pkg::ST_UPD_IR && !tms_s &&
      ir_shift == tap_reconf_pkg::OP_START_RECONF;
  endsequence

  sequence s_line_low;
    ##2 !reconfig_request_oe_n;
  endsequence

  property p_start_walk;
    @(posedge core_clk) disable iff (!arst_n)
      s_start_into_idle |-> s_line_low;
  endproperty
  a_start_walk: assert property (p_start_walk) else $error("start did not drive request");

  property p_bsr_cap;
    @(posedge core_clk) disable iff (!arst_n)
      (tck_rise && state == tap_reconf_pkg::ST_CAP_DR) |=> (bsr == $past(pin_in));
  endproperty
  a_bsr_cap: assert property (p_bsr_cap) else $error("pins not captured");

  property p_extest;
    @(posedge core_clk) disable iff (!arst_n)
      (tck_rise && state == tap_reconf_pkg::ST_UPD_IR)
        |=> (extest_active == ($past(ir_shift) == tap_reconf_pkg::OP_EXTEST));
  endproperty
  a_extest: assert property (p_extest) else $error("extest flag wrong");

endmodule : tap_reconf_ctrl

// >>> hw/tap_reconf_pkg.sv
package tap_reconf_pkg;

  localparam int unsigned IR_LEN         = 10;
  localparam int unsigned BSR_LEN        = 174;
  localparam int unsigned CODE_LEN       = 32;

  localparam logic [9:0] OP_EXTEST       = 10'h000;
  localparam logic [9:0] OP_SAMPLE       = 10'h055;
  localparam logic [9:0] OP_BYPASS       = 10'h3ff;
  localparam logic [9:0] OP_IDCODE       = 10'h059;
  localparam logic [9:0] OP_USERCODE     = 10'h079;
  localparam logic [9:0] OP_START_RECONF = 10'h061;
  localparam logic [9:0] OP_HOLD_RECONF  = 10'h065;

  // Capture value of the two low instruction bits, as the test standard fixes
  localparam logic [1:0] IR_CAPTURE      = 2'h1;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

  typedef enum logic [2:0] {
    SEL_BYPASS, SEL_BSR, SEL_IDCODE, SEL_USERCODE
  } dr_sel_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;

endpackage : tap_reconf_pkg

// >>> test/tap_host.sv
module tap_host (
  // Clock
  input  wire logic                core_clk,
  // Test port
  output tap_reconf_pkg::tap_pins_t pins,
  input  wire logic                tdo,
  input  wire logic                tdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  int oe_bad;

  initial begin
    pins   = '0;
    oe_bad = 0;
  end

  task automatic step(input logic tms, input logic tdi, input logic shifting, output logic o);
    pins.tms = tms;
    pins.tdi = tdi;
    repeat (4) @(negedge core_clk);
    // A released data line has no pull-up, so it reads as the inverse
    o = tdo_oe_n ? ~tdo : tdo;
    if (shifting && tdo_oe_n !== 1'b0) oe_bad++;
    pins.tck = 1'b1;
    repeat (4) @(negedge core_clk);
    pins.tck = 1'b0;
  endtask : step

  task automatic scan(input logic is_ir, input logic [173:0] din, input int n, output logic [173:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, 1'b0, o);
    if (is_ir) step(1'b1, 1'b0, 1'b0, o);
    step(1'b0, 1'b0, 1'b0, o);
    step(1'b0, 1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], 1'b1, o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, 1'b0, o);
    step(1'b0, 1'b0, 1'b0, o);
  endtask : scan
endmodule : tap_host

// >>> test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] ID_VAL = 32'h1357_9bdf;  // Arbitrary value
  localparam logic [31:0] USER   = 32'h5a3c_96e1;

  logic                      core_clk;
  logic                      arst_n;
  tap_reconf_pkg::tap_pins_t pins;
  logic                      tdo;
  logic                      tdo_oe_n;
  logic                      reconfig_request_n;
  logic                      reconfig_request_oe_n;
  logic                      extest_active;
  logic                      target_config_request_n;
  logic [173:0]              pin_in;
  logic [173:0]              pin_out;
  logic [173:0]              din;
  logic [173:0]              dout;
  logic [31:0]               seed;
  logic [31:0]               t;
  logic [9:0]                op;
  logic                      o;
  int                        fails;
  int                        n_compared;

  // Open-drain line with pull-up
  assign target_config_request_n = reconfig_request_oe_n ? 1'b1 : reconfig_request_n;

  tap_reconf_ctrl #(.ID_VALUE(ID_VAL), .USER_VAL(USER)) u_tap_reconf_ctrl (
    .core_clk(core_clk), .arst_n(arst_n), .pins(pins), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .reconfig_request_n(reconfig_request_n), .reconfig_request_oe_n(reconfig_request_oe_n),
    .pin_in(pin_in), .pin_out(pin_out), .extest_active(extest_active));

  tap_host u_tap_host (.core_clk(core_clk), .pins(pins), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

  always #12.5 core_clk = ~core_clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic listed(input logic [9:0] v);
    return v inside {tap_reconf_pkg::OP_EXTEST, tap_reconf_pkg::OP_SAMPLE, tap_reconf_pkg::OP_BYPASS,
                     tap_reconf_pkg::OP_IDCODE, tap_reconf_pkg::OP_USERCODE,
                     tap_reconf_pkg::OP_START_RECONF, tap_reconf_pkg::OP_HOLD_RECONF};
  endfunction : listed

  function automatic logic [15:0] byp(input logic [173:0] d);
    return {d[14:0], 1'b0};
  endfunction : byp

  task automatic fill(output logic [173:0] v);
    logic [191:0] w;
    for (int i = 0; i < 6; i++) w[i*32 +: 32] = xs();
    v = w[173:0];
  endtask : fill

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check

  task automatic load(input logic [9:0] v);
    din = '0;
    din[9:0] = v;
    u_tap_host.scan(1'b1, din, 10, dout);
    check(dout[1:0] === tap_reconf_pkg::IR_CAPTURE, "instruction capture");
  endtask : load

  task automatic scan_dr(input int n);
    fill(din);
    u_tap_host.scan(1'b0, din, n, dout);
  endtask : scan_dr

  task automatic end_of_test();
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #2_000_000;
    fails++;
    end_of_test();
  end

  initial begin
    core_clk   = 1'b0;
    arst_n     = 1'b0;
    pin_in     = '0;
    seed       = 32'h0000_0018;
    fails      = 0;
    n_compared = 0;
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    u_tap_host.step(1'b0, 1'b0, 1'b0, o);
    check(target_config_request_n === 1'b1 && tdo_oe_n === 1'b1, "lines idle after reset");
    scan_dr(32);
    check(dout[31:0] === ID_VAL, "identification after reset");
    load(tap_reconf_pkg::OP_USERCODE);
    scan_dr(32);
    check(dout[31:0] === USER, "user code");
    load(tap_reconf_pkg::OP_IDCODE);
    scan_dr(32);
    check(dout[31:0] === ID_VAL, "identification");
    load(tap_reconf_pkg::OP_BYPASS);
    scan_dr(16);
    check(dout[15:0] === byp(din), "bypass path");
    // Near misses of listed codes in bit 9 come first, then random codes
    for (int k = 0; k < 8; k++) begin
      t  = xs();
      op = (k == 0) ? 10'h255 : (k == 1) ? 10'h261 : (k == 2) ? 10'h265 : t[9:0];
      if (listed(op)) op = 10'h2aa;
      load(op);
      scan_dr(16);
      check(dout[15:0] === byp(din), "unlisted code path");
      check(target_config_request_n === 1'b1, "unlisted code request");
    end
    fill(pin_in);
    load(tap_reconf_pkg::OP_SAMPLE);
    check(extest_active === 1'b0, "sample leaves pins alone");
    scan_dr(174);
    check(dout === pin_in, "sample capture");
    check(pin_out === din, "preload");
    fill(pin_in);
    load(tap_reconf_pkg::OP_EXTEST);
    check(extest_active === 1'b1, "extest active");
    scan_dr(174);
    check(dout === pin_in && pin_out === din, "extest capture and drive");
    load(tap_reconf_pkg::OP_START_RECONF);
    repeat (4) @(negedge core_clk);
    check(target_config_request_n === 1'b0, "request low in idle");
    u_tap_host.step(1'b1, 1'b0, 1'b0, o);
    repeat (2) @(negedge core_clk);
    check(target_config_request_n === 1'b1, "request released");
    u_tap_host.step(1'b0, 1'b0, 1'b0, o);
    u_tap_host.step(1'b1, 1'b0, 1'b0, o);
    u_tap_host.step(1'b1, 1'b0, 1'b0, o);
    u_tap_host.step(1'b0, 1'b0, 1'b0, o);
    // target held in reset keeps its flash side off
    load(tap_reconf_pkg::OP_HOLD_RECONF);
    check(target_config_request_n === 1'b0, "hold low");
    load(tap_reconf_pkg::OP_BYPASS);
    check(target_config_request_n === 1'b0, "hold past other code");
    repeat (5) u_tap_host.step(1'b1, 1'b0, 1'b0, o);
    u_tap_host.step(1'b0, 1'b0, 1'b0, o);
    check(target_config_request_n === 1'b0, "hold past test reset");
    // Power-on reset in mid-run drops the hold and restores identification
    arst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    check(target_config_request_n === 1'b1 && pin_out === '0, "lines released in reset");
    arst_n = 1'b1;
    u_tap_host.step(1'b0, 1'b0, 1'b0, o);
    scan_dr(32);
    check(dout[31:0] === ID_VAL && target_config_request_n === 1'b1, "identification after mid reset");
    load(tap_reconf_pkg::OP_HOLD_RECONF);
    check(target_config_request_n === 1'b0, "hold low again");
    load(tap_reconf_pkg::OP_START_RECONF);
    u_tap_host.step(1'b1, 1'b0, 1'b0, o);
    repeat (2) @(negedge core_clk);
    check(target_config_request_n === 1'b1, "start ends hold");
    check(u_tap_host.oe_bad == 0, "data out enabled while shifting");
    end_of_test();
  end
endmodule : tb
